//--- design/ubb_port.v
/*
  two-channel parallel bit-bang port with shared flush/wake input.
  assumes all inputs synchronous to ref_clk_i; pins resolved outside.
*/
//Function
//- In bit-bang operation a channel's eight lines act as one 8-bit bidirectional bus, bits 7 to 0.
//- Each channel is configured as either the synchronous or the asynchronous variant.
//- Either channel or both may be in bit-bang operation, each with its own bus.
//- A low write strobe pulse marks each host update of the output lines.
//- A falling read strobe edge marks each sample of the lines; the rising edge marks its forwarding to the host.
//- A low strobe on flush_or_wake_n while suspended with remote wakeup enabled requests a bus resume.
//- A low strobe on flush_or_wake_n while not suspended flushes buffered transmit data on the next IN request.
`include "ubb_consts.vh"
module ubb_port (
  // clock, reset and configuration
  input  wire                    ref_clk_i,
  input  wire                    reset_n_i,
  input  wire                    clk_en_i,
  input  wire [1:0]              bitbang_en_i,
  input  wire [1:0]              sync_mode_i,
  input  wire                    remote_wake_en_i,
  input  wire                    bus_active_indicator_n_i,
  input  wire                    flush_or_wake_n_i,

  // channel a
  input  wire [`UBB_DATA_W-1:0]  a_host_data_i,
  input  wire [`UBB_DATA_W-1:0]  a_host_dir_i,
  input  wire                    a_host_write_i,
  input  wire                    a_host_read_i,
  input  wire [`UBB_DATA_W-1:0]  first_channel_io_bus_i,
  output wire [`UBB_DATA_W-1:0]  first_channel_io_bus_o,
  output wire [`UBB_DATA_W-1:0]  first_channel_io_bus_oe_o,
  output wire                    a_pin_update_strobe_n_o,
  output wire                    a_pin_sample_strobe_n_o,
  output wire [`UBB_DATA_W-1:0]  a_sample_data_o,
  output wire                    a_sample_valid_o,

  // channel b
  input  wire [`UBB_DATA_W-1:0]  b_host_data_i,
  input  wire [`UBB_DATA_W-1:0]  b_host_dir_i,
  input  wire                    b_host_write_i,
  input  wire                    b_host_read_i,
  input  wire [`UBB_DATA_W-1:0]  second_channel_io_bus_i,
  output wire [`UBB_DATA_W-1:0]  second_channel_io_bus_o,
  output wire [`UBB_DATA_W-1:0]  second_channel_io_bus_oe_o,
  output wire                    b_pin_update_strobe_n_o,
  output wire                    b_pin_sample_strobe_n_o,
  output wire [`UBB_DATA_W-1:0]  b_sample_data_o,
  output wire                    b_sample_valid_o,

  // usb side requests
  output reg                     resume_req_o,
  output reg                     flush_req_o
);

  localparam integer W   = `UBB_DATA_W;
  localparam integer NCH = 2;

  // reset and flush/wake path
  reg              rst_s1_reg;
  reg              rst_s2_reg;
  reg              fw_s1_reg;
  reg              fw_s2_reg;
  reg              fw_d_reg;
  reg              susp_reg;
  reg              wake_en_reg;
  wire             rst_n;
  wire             fw_fall;
  wire             wake_ok;
  wire             flush_ok;

  // both channels packed, channel a in the low half
  wire [NCH*W-1:0] host_data;
  wire [NCH*W-1:0] host_dir;
  wire [NCH-1:0]   host_write;
  wire [NCH-1:0]   host_read;
  wire [NCH*W-1:0] pin_in;
  wire [NCH*W-1:0] pin_out;
  wire [NCH*W-1:0] pin_oe;
  wire [NCH-1:0]   upd_strobe_n;
  wire [NCH-1:0]   smp_strobe_n;
  wire [NCH*W-1:0] smp_data;
  wire [NCH-1:0]   smp_valid;
  genvar           ch;

  // reset released through two flops; assertion stays asynchronous
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s2_reg <= rst_s1_reg;
    end
  end

  assign rst_n = rst_s2_reg;

  // first stage feeds only the second, never the detector
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fw_s1_reg <= 1'b1;
    end else if (clk_en_i) begin
      fw_s1_reg <= flush_or_wake_n_i;
    end
  end

  // second stage and its delayed copy fw_d_reg are what the detector reads
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fw_s2_reg <= 1'b1;
    end else if (clk_en_i) begin
      fw_s2_reg <= fw_s1_reg;
    end
  end

  // idle level after reset is high, so reset leaves no false edge
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fw_d_reg <= 1'b1;
    end else if (clk_en_i) begin
      fw_d_reg <= fw_s2_reg;
    end
  end

  // levels pass one flop, so they run one cycle ahead of the strobe's second stage
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      susp_reg <= 1'b0;
    end else if (clk_en_i) begin
      susp_reg <= bus_active_indicator_n_i;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wake_en_reg <= 1'b0;
    end else if (clk_en_i) begin
      wake_en_reg <= remote_wake_en_i;
    end
  end

  assign fw_fall  = fw_d_reg & ~fw_s2_reg;
  assign wake_ok  = susp_reg & wake_en_reg;
  assign flush_ok = ~susp_reg;

  // one-cycle pulses toward the usb side; never both at once
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      resume_req_o <= 1'b0;
    end else if (clk_en_i) begin
      resume_req_o <= fw_fall & wake_ok;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flush_req_o <= 1'b0;
    end else if (clk_en_i) begin
      flush_req_o <= fw_fall & flush_ok;
    end
  end

  // requests and pins gathered for the shared channel body
  assign host_data  = {b_host_data_i, a_host_data_i};
  assign host_dir   = {b_host_dir_i, a_host_dir_i};
  assign host_write = {b_host_write_i, a_host_write_i};
  assign host_read  = {b_host_read_i, a_host_read_i};
  assign pin_in     = {second_channel_io_bus_i, first_channel_io_bus_i};

  // channel a outputs
  assign first_channel_io_bus_o     = pin_out[W-1:0];
  assign first_channel_io_bus_oe_o  = pin_oe[W-1:0];
  assign a_pin_update_strobe_n_o    = upd_strobe_n[0];
  assign a_pin_sample_strobe_n_o    = smp_strobe_n[0];
  assign a_sample_data_o            = smp_data[W-1:0];
  assign a_sample_valid_o           = smp_valid[0];

  // channel b outputs
  assign second_channel_io_bus_o    = pin_out[2*W-1:W];
  assign second_channel_io_bus_oe_o = pin_oe[2*W-1:W];
  assign b_pin_update_strobe_n_o    = upd_strobe_n[1];
  assign b_pin_sample_strobe_n_o    = smp_strobe_n[1];
  assign b_sample_data_o            = smp_data[2*W-1:W];
  assign b_sample_valid_o           = smp_valid[1];

  // either channel or both may be enabled, each with its own bus
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      ubb_channel u_chan (
        .clk_i                 (ref_clk_i),
        .rst_n_i               (rst_n),
        .ce_i                  (clk_en_i),
        .enable_i              (bitbang_en_i[ch]),
        .sync_mode_i           (sync_mode_i[ch]),
        .host_data_i           (host_data[ch*W +: W]),
        .host_dir_i            (host_dir[ch*W +: W]),
        .host_write_i          (host_write[ch]),
        .host_read_i           (host_read[ch]),
        .pin_i                 (pin_in[ch*W +: W]),
        .pin_o                 (pin_out[ch*W +: W]),
        .pin_oe_o              (pin_oe[ch*W +: W]),
        .pin_update_strobe_n_o (upd_strobe_n[ch]),
        .pin_sample_strobe_n_o (smp_strobe_n[ch]),
        .sample_data_o         (smp_data[ch*W +: W]),
        .sample_valid_o        (smp_valid[ch])
      );
    end
  endgenerate
endmodule // ubb_port

//--- include/ubb_consts.vh
/*
  constants for the two-channel parallel bit-bang port.
  assumes a 100 MHz core clock and no software-visible registers.
*/
`ifndef UBB_CONSTS_VH
`define UBB_CONSTS_VH
`define UBB_DATA_W        8
`define UBB_CLK_PERIOD_NS 10
`define UBB_STROBE_NS     10
`define UBB_STROBE_CYC    ((`UBB_STROBE_NS + `UBB_CLK_PERIOD_NS - 1) / `UBB_CLK_PERIOD_NS)
`define UBB_CNT_W         4
`define UBB_DATA_RST      8'h00
`define UBB_MODE_SYNC     1'b1
`define UBB_MODE_ASYNC    1'b0
`endif

//--- design/ubb_channel.v
/*
  one bit-bang channel: eight bidirectional lines, update and sample strobes.
  assumes host-side requests are single-cycle pulses synchronous to ref_clk_i.
*/
`include "ubb_consts.vh"
module ubb_channel (
  input  wire                    clk_i,
  input  wire                    rst_n_i,
  input  wire                    ce_i,
  input  wire                    enable_i,
  input  wire                    sync_mode_i,
  input  wire [`UBB_DATA_W-1:0]  host_data_i,
  input  wire [`UBB_DATA_W-1:0]  host_dir_i,
  input  wire                    host_write_i,
  input  wire                    host_read_i,
  input  wire [`UBB_DATA_W-1:0]  pin_i,
  output reg  [`UBB_DATA_W-1:0]  pin_o,
  output reg  [`UBB_DATA_W-1:0]  pin_oe_o,
  output reg                     pin_update_strobe_n_o,
  output reg                     pin_sample_strobe_n_o,
  output reg  [`UBB_DATA_W-1:0]  sample_data_o,
  output reg                     sample_valid_o
);
  localparam integer          STB_CYC_INT = `UBB_STROBE_CYC;
  // count is cut to the counter width on purpose; the value is small
  localparam [`UBB_CNT_W-1:0] STB_CYC     = STB_CYC_INT[`UBB_CNT_W-1:0];
  reg [`UBB_CNT_W-1:0] wr_cnt_reg;
  reg [`UBB_CNT_W-1:0] rd_cnt_reg;
  wire do_read;
  // sync variant samples on every write, async on explicit read requests
  assign do_read = enable_i & ((sync_mode_i & host_write_i) | (~sync_mode_i & host_read_i));
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o                 <= `UBB_DATA_RST;
      pin_oe_o              <= `UBB_DATA_RST;
      pin_update_strobe_n_o <= 1'b1;
      pin_sample_strobe_n_o <= 1'b1;
      sample_data_o         <= `UBB_DATA_RST;
      sample_valid_o        <= 1'b0;
      wr_cnt_reg            <= {`UBB_CNT_W{1'b0}};
      rd_cnt_reg            <= {`UBB_CNT_W{1'b0}};
    end else if (ce_i) begin
      sample_valid_o <= 1'b0;
      if (!enable_i) begin
        pin_oe_o <= `UBB_DATA_RST;
      end
      if (enable_i && host_write_i) begin
        pin_o                 <= host_data_i;
        pin_oe_o              <= host_dir_i;
        pin_update_strobe_n_o <= 1'b0;
        wr_cnt_reg            <= STB_CYC;
      end else if (wr_cnt_reg > 1) begin
        wr_cnt_reg <= wr_cnt_reg - 1'b1;
      end else begin
        wr_cnt_reg            <= {`UBB_CNT_W{1'b0}};
        pin_update_strobe_n_o <= 1'b1;
      end
      // strobe falls at sample, rises one stretch later when value is forwarded
      if (do_read) begin
        sample_data_o         <= pin_i;
        pin_sample_strobe_n_o <= 1'b0;
        rd_cnt_reg            <= STB_CYC;
      end else if (rd_cnt_reg > 1) begin
        rd_cnt_reg <= rd_cnt_reg - 1'b1;
      end else if (rd_cnt_reg == 1) begin
        rd_cnt_reg            <= {`UBB_CNT_W{1'b0}};
        pin_sample_strobe_n_o <= 1'b1;
        sample_valid_o        <= 1'b1;
      end
    end
  end
endmodule // ubb_channel

//--- sim/ubb_port_asserts.sv
/* checker on channel A and the flush/wake path of ubb_port.
   assumes a bind onto ubb_port. */
module ubb_port_asserts (
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  input wire logic       clk_en_i,
  input wire logic       remote_wake_en_i,
  input wire logic       bus_active_indicator_n_i,
  input wire logic       flush_or_wake_n_i,
  input wire logic       resume_req_o,
  input wire logic       flush_req_o,
  input wire logic       a_host_write_i,
  input wire logic       a_host_read_i,
  input wire logic       a_pin_update_strobe_n_o,
  input wire logic       a_pin_sample_strobe_n_o,
  input wire logic       a_sample_valid_o,
  input wire logic [1:0] bitbang_en_i,
  input wire logic [1:0] sync_mode_i,
  input wire logic [7:0] a_host_data_i,
  input wire logic [7:0] a_host_dir_i,
  input wire logic [7:0] a_sample_data_o,
  input wire logic [7:0] first_channel_io_bus_i,
  input wire logic [7:0] first_channel_io_bus_o,
  input wire logic [7:0] first_channel_io_bus_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire go = clk_en_i && bitbang_en_i[0];
  sequence s_rd; go && !sync_mode_i[0] && a_host_read_i ##1 clk_en_i && !a_host_read_i; endsequence
  sequence s_fall; clk_en_i && !flush_or_wake_n_i && $past(flush_or_wake_n_i); endsequence
  property p_wr_strobe; go && a_host_write_i |=> !a_pin_update_strobe_n_o; endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("update strobe missing");
  property p_wr_pins; go && a_host_write_i |=> first_channel_io_bus_oe_o == $past(a_host_dir_i)
    && (first_channel_io_bus_o & first_channel_io_bus_oe_o) == ($past(a_host_data_i) & $past(a_host_dir_i));
  endproperty
  a_wr_pins: assert property (p_wr_pins) else $error("pins not updated");
  property p_rd; s_rd |-> !a_pin_sample_strobe_n_o ##1 (a_pin_sample_strobe_n_o && a_sample_valid_o); endproperty
  a_rd: assert property (p_rd) else $error("sample strobe wrong");
  property p_rd_data; s_rd |-> a_sample_data_o == $past(first_channel_io_bus_i); endproperty
  a_rd_data: assert property (p_rd_data) else $error("sample data wrong");
  property p_sync; go && sync_mode_i[0] && a_host_write_i |=> !a_pin_sample_strobe_n_o; endproperty
  a_sync: assert property (p_sync) else $error("sync write did not sample");
  property p_off; clk_en_i && !bitbang_en_i[0] |=> first_channel_io_bus_oe_o == 8'h00; endproperty
  a_off: assert property (p_off) else $error("disabled channel drives");
  property p_resume; s_fall and bus_active_indicator_n_i && remote_wake_en_i |-> ##3 resume_req_o; endproperty
  a_resume: assert property (p_resume) else $error("resume missing");
  property p_flush; s_fall and !bus_active_indicator_n_i |-> ##3 (flush_req_o && !resume_req_o); endproperty
  a_flush: assert property (p_flush) else $error("flush missing");
endmodule // ubb_port_asserts

//--- sim/ubb_pins_model.sv
/* far-side parallel logic on one channel's eight lines.
   assumes per-bit enables high while the port drives. */
module ubb_pins_model (
  input  wire logic [7:0] dev_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ext_i,
  input  wire logic       upd_n_i,
  output logic      [7:0] bus_o,
  output logic      [7:0] seen_o
);
  // released bits show the far side, never a stale device value
  assign bus_o = (oe_i & dev_i) | (~oe_i & ext_i);
  always @(posedge upd_n_i) seen_o <= bus_o;
endmodule // ubb_pins_model

//--- sim/ubb_port_bench.sv
/* bench for ubb_port with a pin model per channel.
   assumes design, model and checker compiled before it. */
module ubb_port_bench;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, rst_n = 0, wk = 0, sp = 0, fw = 1, aw = 0, ar = 0, bw = 0, br = 0, ce = 1;
  logic [1:0] en = 2'b11, sy = 2'b00;
  logic [7:0] ad = 0, adr = 0, bd = 0, bdr = 0;
  wire [7:0] ab, ao, aoe, ax, as, bb, bo, boe, bx, bs;
  wire au, ak, av, bu, bk, bv, rs, fl;
  int fail_count = 0, comparisons = 0;
  always #5 clk = ~clk;
  ubb_port uut (.ref_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(ce), .bitbang_en_i(en), .sync_mode_i(sy),
    .remote_wake_en_i(wk), .bus_active_indicator_n_i(sp), .flush_or_wake_n_i(fw), .a_host_data_i(ad),
    .a_host_dir_i(adr), .a_host_write_i(aw), .a_host_read_i(ar), .first_channel_io_bus_i(ab),
    .first_channel_io_bus_o(ao), .first_channel_io_bus_oe_o(aoe), .a_pin_update_strobe_n_o(au),
    .a_pin_sample_strobe_n_o(ak), .a_sample_data_o(ax), .a_sample_valid_o(av), .b_host_data_i(bd),
    .b_host_dir_i(bdr), .b_host_write_i(bw), .b_host_read_i(br), .second_channel_io_bus_i(bb),
    .second_channel_io_bus_o(bo), .second_channel_io_bus_oe_o(boe), .b_pin_update_strobe_n_o(bu),
    .b_pin_sample_strobe_n_o(bk), .b_sample_data_o(bx), .b_sample_valid_o(bv), .resume_req_o(rs),
    .flush_req_o(fl));
  ubb_pins_model pa (.dev_i(ao), .oe_i(aoe), .ext_i(8'h3c), .upd_n_i(au), .bus_o(ab), .seen_o(as));
  ubb_pins_model pb (.dev_i(bo), .oe_i(boe), .ext_i(8'hc3), .upd_n_i(bu), .bus_o(bb), .seen_o(bs));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask
  task t_write;
    ad = 8'ha5; adr = 8'hf0; aw = 1; bd = 8'h5a; bdr = 8'hff; bw = 1; tick;
    aw = 0; bw = 0;
    chk("a_update", au, 0);
    chk("a_bus", ab, 8'hac);
    chk("b_bus", bb, 8'h5a);
    tick;
    chk("a_update_end", au, 1);
    chk("a_seen", as, 8'hac);
  endtask
  task t_read;
    ar = 1; tick;
    ar = 0;
    chk("a_sample", ax, 8'hac);
    chk("a_smp_low", ak, 0);
    tick;
    chk("a_smp_rise", {ak, av}, 2'b11);
  endtask
  task t_sync;
    sy = 2'b11; bd = 8'h11; bdr = 8'h0f; bw = 1; aw = 1; tick;
    bw = 0; aw = 0;
    chk("b_sync_sample", bx, 8'h5a);
    chk("a_sync_sample", ax, 8'hac);
    chk("b_smp_low", bk, 0);
    chk("b_update", bu, 0);
    chk("b_bus_new", bb, 8'hc1);
    tick;
    chk("b_valid", bv, 1);
    chk("b_seen", bs, 8'hc1);
  endtask
  task t_off;
    en = 2'b10; tick;
    ad = 8'hff; adr = 8'hff; aw = 1; tick;
    aw = 0;
    chk("a_oe_off", aoe, 8'h00);
    chk("a_no_update", au, 1);
    en = 2'b11; ce = 0; aw = 1; tick;
    aw = 0; ce = 1;
    chk("a_frozen", au, 1);
  endtask
  task automatic fall(logic s, logic w);
    sp = s; wk = w; tick(2);
    fw = 0; tick(3);
  endtask
  task t_wake;
    fall(1, 1); chk("resume", rs, 1);
    fw = 1; fall(1, 0); chk("no_resume", rs, 0);
    chk("no_flush", fl, 0);
    fw = 1; fall(0, 1); chk("flush", {fl, rs}, 2'b10);
    fw = 1;
  endtask
  task wrap_up;
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(4); rst_n = 1; tick(3);
    t_write; t_read; t_sync; t_off; t_wake;
    wrap_up;
  end
  initial begin
    #20000; fail_count++; wrap_up;
  end
endmodule // ubb_port_bench
bind ubb_port ubb_port_asserts chk_a (
  .ref_clk_i                 (ref_clk_i),
  .reset_n_i                 (reset_n_i),
  .clk_en_i                  (clk_en_i),
  .remote_wake_en_i          (remote_wake_en_i),
  .bus_active_indicator_n_i  (bus_active_indicator_n_i),
  .flush_or_wake_n_i         (flush_or_wake_n_i),
  .resume_req_o              (resume_req_o),
  .flush_req_o               (flush_req_o),
  .a_host_write_i            (a_host_write_i),
  .a_host_read_i             (a_host_read_i),
  .a_pin_update_strobe_n_o   (a_pin_update_strobe_n_o),
  .a_pin_sample_strobe_n_o   (a_pin_sample_strobe_n_o),
  .a_sample_valid_o          (a_sample_valid_o),
  .bitbang_en_i              (bitbang_en_i),
  .sync_mode_i               (sync_mode_i),
  .a_host_data_i             (a_host_data_i),
  .a_host_dir_i              (a_host_dir_i),
  .a_sample_data_o           (a_sample_data_o),
  .first_channel_io_bus_i    (first_channel_io_bus_i),
  .first_channel_io_bus_o    (first_channel_io_bus_o),
  .first_channel_io_bus_oe_o (first_channel_io_bus_oe_o)
);
